// ---- hdl/pdww_pkg.sv ----
// Types shared by the power-down/wake watchdog block
package pdww_pkg;

  // Gray sequence: run -> halted -> waking -> interrupt gap
  typedef enum logic [1:0] {
    PDWW_RUN  = 2'h0,
    PDWW_HALT = 2'h1,
    PDWW_WAKE = 2'h3,
    PDWW_IRQ  = 2'h2
  } pdww_state_e;

  typedef enum logic [1:0] {
    PDWW_CAUSE_NONE = 2'h0,
    PDWW_CAUSE_PORT = 2'h1,
    PDWW_CAUSE_IRQ  = 2'h2,
    PDWW_CAUSE_WDOG = 2'h3
  } pdww_cause_e;

  typedef enum logic [1:0] {
    PDWW_PAIR_NONE   = 2'h0,
    PDWW_PAIR_FIRST  = 2'h1,
    PDWW_PAIR_SECOND = 2'h2
  } pdww_pair_e;

  // Core-side instruction strobes, one cycle each
  typedef struct packed {
    logic stop;
    logic single_clear;
    logic pair_first;
    logic pair_second;
  } pdww_instr_s;

  // Whole state of the block
  typedef struct packed {
    pdww_state_e state;
    pdww_cause_e cause;
    pdww_pair_e  pair_last;
    logic [2:0]  rst_sync;
    logic        rst_lvl;
    logic [23:0] port_sync;
    logic [7:0]  port_lvl;
    logic [2:0]  osc_sync;
    logic        osc_lvl;
    logic [1:0]  sysdiv;
    logic [14:0] prescale;
    logic        final_stage;
    logic [10:0] wake_cnt;
    logic [3:0]  irq_mask;
    logic [3:0]  irq_cause;
    logic        power_down_flag;
    logic        timeout_flag;
    logic [31:0] config_word;
    logic        bus_ack;
    logic [31:0] readdata;
    logic        resume_next;
    logic        irq_entry;
    logic        wdog_reset;
    logic        pc_sp_reset;
  } pdww_state_s;

endpackage

// ---- hdl/pdww_regs.svh ----
// Register offsets, field positions, reset values and timing counts of the power-down/wake watchdog
`ifndef PDWW_REGS_SVH
`define PDWW_REGS_SVH

// Byte offsets on the register bus
`define PDWW_CONFIG_OFS      4'h0
`define PDWW_STATUS_OFS      4'h4
`define PDWW_COUNT_OFS       4'h8

// Configuration word fields
`define PDWW_CFG_ENABLE_BIT  0
`define PDWW_CFG_SRC_BIT     1
`define PDWW_CFG_PAIR_BIT    2
`define PDWW_CFG_WAKE_LSB    8
`define PDWW_CFG_WAKE_MSB    15
`define PDWW_CFG_RESET       32'h0000_0001

// Status word fields
`define PDWW_ST_PDF_BIT      0
`define PDWW_ST_TMO_BIT      1
`define PDWW_ST_STATE_LSB    2
`define PDWW_ST_CAUSE_LSB    4

// Timing: wake delay in system clock periods, prescaler width, divide-by-four wrap
`define PDWW_WAKE_PERIODS    11'h400
`define PDWW_WAKE_CYCLES     (`PDWW_WAKE_PERIODS - 11'h001)
`define PDWW_PRESCALE_BITS   15
`define PDWW_SYSDIV_LAST     2'h3
`define PDWW_PIN_FLOPS       3

`endif

// ---- hdl/pdww_watchdog.sv ----
// Power-down entry, wake sequencing and watchdog timer with Avalon-MM register slave
//
// Chosen here: register access over Avalon-MM and the address map.
`timescale 1ns/10ps
`include "pdww_regs.svh"

module pdww_watchdog
  import pdww_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire pdww_instr_s instr,
  input  wire logic        external_reset_pin_n,
  input  wire logic [7:0]  wake_port,
  input  wire logic        wdog_osc,
  input  wire logic [3:0]  irq_req,
  input  wire logic [3:0]  irq_en,
  input  wire logic        stack_full,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             core_halt,
  output logic             sys_osc_run,
  output logic             system_reset,
  output logic             wdog_reset,
  output logic             pc_sp_reset,
  output logic             resume_next,
  output logic             irq_entry
);

  pdww_state_s r;
  pdww_state_s next_r;

  // Configuration fields decoded from the config word
  logic       cfg_enable;
  logic       cfg_src_sys;
  logic       cfg_pair;
  logic [7:0] cfg_wake_en;

  assign cfg_enable  = r.config_word[`PDWW_CFG_ENABLE_BIT];
  assign cfg_src_sys = r.config_word[`PDWW_CFG_SRC_BIT];
  assign cfg_pair    = r.config_word[`PDWW_CFG_PAIR_BIT];
  assign cfg_wake_en = r.config_word[`PDWW_CFG_WAKE_MSB:`PDWW_CFG_WAKE_LSB];

  // Outputs decoded from state flops; waitrequest also gated by the bus read/write request
  assign core_halt       = (r.state != PDWW_RUN);
  assign sys_osc_run     = (r.state != PDWW_HALT);
  assign system_reset    = ~r.rst_lvl;
  assign wdog_reset      = r.wdog_reset;
  assign pc_sp_reset     = r.pc_sp_reset;
  assign resume_next     = r.resume_next;
  assign irq_entry       = r.irq_entry;
  assign avs_readdata    = r.readdata;
  assign avs_waitrequest = (avs_read | avs_write) & ~r.bus_ack;

  // Next-state logic for the whole block
  always_comb begin
    logic        rst_new;
    logic [7:0]  port_new;
    logic [7:0]  port_fall;
    logic        osc_new;
    logic        osc_tick;
    logic        wdog_tick;
    logic [15:0] pre_sum;
    logic        overflow;
    logic        clear_ok;
    logic        wake_irq;
    logic        serviceable;
    logic [31:0] rd;
    rst_new     = r.rst_lvl;
    port_new    = r.port_lvl;
    port_fall   = 8'h00;
    osc_new     = r.osc_lvl;
    osc_tick    = 1'b0;
    wdog_tick   = 1'b0;
    pre_sum     = 16'h0000;
    overflow    = 1'b0;
    clear_ok    = 1'b0;
    wake_irq    = 1'b0;
    serviceable = 1'b0;
    rd          = 32'h0000_0000;
    next_r      = r;

    // Pulses last one cycle
    next_r.resume_next = 1'b0;
    next_r.irq_entry   = 1'b0;
    next_r.wdog_reset  = 1'b0;
    next_r.pc_sp_reset = 1'b0;

    // Pin synchronisers; a level counts once the last two stages agree
    next_r.rst_sync  = {r.rst_sync[1:0], external_reset_pin_n};
    next_r.port_sync = {r.port_sync[15:0], wake_port};
    next_r.osc_sync  = {r.osc_sync[1:0], wdog_osc};
    if (r.rst_sync[2] == r.rst_sync[1]) begin
      rst_new = r.rst_sync[2];
    end
    for (int i = 0; i < 8; i++) begin
      if (r.port_sync[16 + i] == r.port_sync[8 + i]) begin
        port_new[i] = r.port_sync[16 + i];
      end
    end
    if (r.osc_sync[2] == r.osc_sync[1]) begin
      osc_new = r.osc_sync[2];
    end
    next_r.rst_lvl  = rst_new;
    next_r.port_lvl = port_new;
    next_r.osc_lvl  = osc_new;
    port_fall       = r.port_lvl & ~port_new & cfg_wake_en;
    osc_tick        = ~r.osc_lvl & osc_new;

    // Watchdog clock select; system_clock_freq/4 divider is frozen while halted
    if (cfg_src_sys) begin
      if (r.state != PDWW_HALT) begin
        next_r.sysdiv = r.sysdiv + 2'h1;
        wdog_tick     = (r.sysdiv == `PDWW_SYSDIV_LAST);
      end
    end else begin
      wdog_tick = osc_tick;
    end

    // Prescaler then final stage; overflow when the carry meets a set final stage
    if (cfg_enable && wdog_tick) begin
      pre_sum         = {1'b0, r.prescale} + 16'h0001;
      next_r.prescale = pre_sum[`PDWW_PRESCALE_BITS - 1:0];
      if (pre_sum[`PDWW_PRESCALE_BITS]) begin
        overflow           = r.final_stage;
        next_r.final_stage = ~r.final_stage;
      end
    end

    // Clear instructions: ignored when the watchdog is disabled
    if (cfg_enable && (r.state == PDWW_RUN) && !instr.stop) begin
      if (!cfg_pair) begin
        clear_ok = instr.single_clear;
      end else if (instr.pair_first) begin
        clear_ok         = (r.pair_last == PDWW_PAIR_SECOND);
        next_r.pair_last = PDWW_PAIR_FIRST;
      end else if (instr.pair_second) begin
        clear_ok         = (r.pair_last == PDWW_PAIR_FIRST);
        next_r.pair_last = PDWW_PAIR_SECOND;
      end
    end
    if (clear_ok) begin
      next_r.final_stage     = 1'b0;
      next_r.power_down_flag = 1'b0;
    end

    // New interrupt requests only; those pending at entry are masked
    wake_irq = |(irq_req & ~r.irq_mask);

    // Power state sequence
    unique case (r.state)
      PDWW_RUN: begin
        if (instr.stop) begin
          next_r.state           = PDWW_HALT;
          next_r.power_down_flag = 1'b1;
          next_r.timeout_flag    = 1'b0;
          next_r.prescale        = '0;
          next_r.final_stage     = 1'b0;
          next_r.sysdiv          = 2'h0;
          next_r.irq_mask        = irq_req;
          next_r.cause           = PDWW_CAUSE_NONE;
        end else if (overflow) begin
          next_r.wdog_reset = 1'b1;
          next_r.pair_last  = PDWW_PAIR_NONE;
        end
      end
      PDWW_HALT: begin
        // Wake events leave the halt at once so the oscillator restarts first
        if (overflow) begin
          next_r.state    = PDWW_WAKE;
          next_r.cause    = PDWW_CAUSE_WDOG;
          next_r.wake_cnt = `PDWW_WAKE_CYCLES;
        end else if (|port_fall) begin
          next_r.state    = PDWW_WAKE;
          next_r.cause    = PDWW_CAUSE_PORT;
          next_r.wake_cnt = `PDWW_WAKE_CYCLES;
        end else if (wake_irq) begin
          next_r.state     = PDWW_WAKE;
          next_r.cause     = PDWW_CAUSE_IRQ;
          next_r.irq_cause = irq_req & ~r.irq_mask;
          next_r.wake_cnt  = `PDWW_WAKE_CYCLES;
        end
      end
      PDWW_WAKE: begin
        // Wake delay, counted in system clock periods
        if (r.wake_cnt != 11'h000) begin
          next_r.wake_cnt = r.wake_cnt - 11'h001;
        end else begin
          serviceable = |(r.irq_cause & irq_en) & ~stack_full;
          unique case (r.cause)
            PDWW_CAUSE_WDOG: begin
              next_r.state       = PDWW_RUN;
              next_r.pc_sp_reset = 1'b1;
            end
            PDWW_CAUSE_IRQ: begin
              if (serviceable) begin
                next_r.state = PDWW_IRQ;
              end else begin
                next_r.state       = PDWW_RUN;
                next_r.resume_next = 1'b1;
              end
            end
            default: begin
              next_r.state       = PDWW_RUN;
              next_r.resume_next = 1'b1;
            end
          endcase
        end
      end
      PDWW_IRQ: begin
        next_r.state     = PDWW_RUN;
        next_r.irq_entry = 1'b1;
      end
    endcase

    // Time-out flag: an overflow wins over the stop's clear
    if (overflow && cfg_enable) begin
      next_r.timeout_flag = 1'b1;
    end

    // External reset low: full reset of sequence and watchdog, flags kept
    if (!r.rst_lvl) begin
      next_r.state       = PDWW_RUN;
      next_r.prescale    = '0;
      next_r.final_stage = 1'b0;
      next_r.sysdiv      = 2'h0;
      next_r.pair_last   = PDWW_PAIR_NONE;
      next_r.wake_cnt    = 11'h000;
      next_r.irq_mask    = 4'h0;
      next_r.resume_next = 1'b0;
      next_r.irq_entry   = 1'b0;
      next_r.wdog_reset  = 1'b0;
      next_r.pc_sp_reset = 1'b0;
    end

    // Register slave: one wait cycle, then answer with data from a flop
    next_r.bus_ack = (avs_read | avs_write) & ~r.bus_ack;
    unique case (avs_address)
      `PDWW_CONFIG_OFS: rd = r.config_word;
      `PDWW_STATUS_OFS: begin
        rd[`PDWW_ST_PDF_BIT]                          = r.power_down_flag;
        rd[`PDWW_ST_TMO_BIT]                          = r.timeout_flag;
        rd[`PDWW_ST_STATE_LSB + 1:`PDWW_ST_STATE_LSB] = r.state;
        rd[`PDWW_ST_CAUSE_LSB + 1:`PDWW_ST_CAUSE_LSB] = r.cause;
      end
      `PDWW_COUNT_OFS: rd = {16'h0000, r.final_stage, r.prescale};
      default: rd = 32'h0000_0000;
    endcase
    if (avs_read && !r.bus_ack) begin
      next_r.readdata = rd;
    end
    // Writes take effect on the edge where waitrequest is low
    if (avs_write && r.bus_ack && (avs_address == `PDWW_CONFIG_OFS)) begin
      next_r.config_word = avs_writedata;
    end
  end

  // State register; power-on reset clears both flags
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r             <= '0;
      r.state       <= PDWW_RUN;
      r.rst_sync    <= 3'h7;
      r.rst_lvl     <= 1'b1;
      r.port_sync   <= 24'hFF_FFFF;
      r.port_lvl    <= 8'hFF;
      r.config_word <= `PDWW_CFG_RESET;
    end else begin
      r <= next_r;
    end
  end

endmodule

// ---- testbench/pdww_assertions.sv ----
// Concurrent checks on the power-down/wake watchdog ports
`timescale 1ns/10ps
module pdww_assertions
  import pdww_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset_n,
  input wire pdww_instr_s instr,
  input wire logic        external_reset_pin_n,
  input wire logic        core_halt,
  input wire logic        sys_osc_run,
  input wire logic        system_reset,
  input wire logic        wdog_reset,
  input wire logic        pc_sp_reset,
  input wire logic        resume_next,
  input wire logic        irq_entry
);
  logic [10:0] wake_age;

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Cycles spent waking; zeroed while the oscillator is stopped
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      wake_age <= 11'h000;
    else if (!sys_osc_run)
      wake_age <= 11'h000;
    else if (core_halt)
      wake_age <= wake_age + 11'h001;
  end

  AST_STOP_HALT: assert property (instr.stop && !core_halt && !system_reset |=> core_halt)
    else $error("stop did not halt the core");
  AST_HALT_CAUSE: assert property ($rose(core_halt) |-> $past(instr.stop))
    else $error("halt without stop");
  AST_OSC_STOP: assert property (!sys_osc_run |-> core_halt)
    else $error("oscillator off while running");
  AST_RESUME_DELAY: assert property (resume_next |-> wake_age == 11'h400)
    else $error("resume not after the wake delay");
  AST_IRQ_DELAY: assert property (irq_entry |-> wake_age inside {[11'h401:11'h402]})
    else $error("interrupt entry timing wrong");
  AST_RESUME_EXCL: assert property (resume_next |-> !irq_entry && !pc_sp_reset && $past(core_halt))
    else $error("resume overlaps another exit");
  AST_WDOG_RUN: assert property (wdog_reset |-> !$past(core_halt))
    else $error("device reset while halted");
  AST_PCSP_WAKE: assert property (pc_sp_reset |-> wake_age == 11'h400)
    else $error("counter reset outside a time-out wake");
  AST_EXT_RUN: assert property (system_reset |=> !core_halt)
    else $error("external reset left the core halted");
  AST_PIN_RESET: assert property ($fell(external_reset_pin_n) |-> ##[2:6] system_reset)
    else $error("reset pin not followed by reset");

  // Main paths that the bench should reach
  cover property (resume_next);
  cover property (irq_entry);
  cover property ($rose(system_reset));
endmodule

bind pdww_watchdog pdww_assertions i_pdww_assertions (
  .clk(clk), .reset_n(reset_n), .instr(instr), .external_reset_pin_n(external_reset_pin_n),
  .core_halt(core_halt), .sys_osc_run(sys_osc_run), .system_reset(system_reset), .wdog_reset(wdog_reset),
  .pc_sp_reset(pc_sp_reset), .resume_next(resume_next), .irq_entry(irq_entry));

// ---- testbench/pdww_core_model.sv ----
// Processor-core model issuing stop and watchdog clear instructions
`timescale 1ns/10ps
module pdww_core_model
  import pdww_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  core_halt,
  output pdww_instr_s instr
);
  initial instr = '0;

  // One-cycle strobe; a halted core executes nothing, so wait for it to run
  task automatic exec(input logic [3:0] op);
    int n;
    n = 0;
    while (core_halt !== 1'b0 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    @(posedge clk);
    instr <= op;
    @(posedge clk);
    instr <= '0;
  endtask
endmodule

// ---- testbench/pdww_watchdog_bench.sv ----
// Self-checking bench for the power-down/wake watchdog
`timescale 1ns/10ps
`include "pdww_regs.svh"
module pdww_watchdog_bench
  import pdww_pkg::*;
;
  logic        clk, reset_n, external_reset_pin_n, wdog_osc, stack_full, avs_read, avs_write;
  pdww_instr_s instr;
  logic [7:0]  wake_port;
  logic [3:0]  irq_req, irq_en, avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic        avs_waitrequest, core_halt, sys_osc_run, system_reset;
  logic        wdog_reset, pc_sp_reset, resume_next, irq_entry;
  int          fail_count, check_count, n;

  pdww_watchdog i_pdww_watchdog (.clk(clk), .reset_n(reset_n), .instr(instr),
    .external_reset_pin_n(external_reset_pin_n), .wake_port(wake_port), .wdog_osc(wdog_osc),
    .irq_req(irq_req), .irq_en(irq_en), .stack_full(stack_full), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .core_halt(core_halt),
    .sys_osc_run(sys_osc_run), .system_reset(system_reset), .wdog_reset(wdog_reset),
    .pc_sp_reset(pc_sp_reset), .resume_next(resume_next), .irq_entry(irq_entry));

  pdww_core_model i_pdww_core_model (.clk(clk), .core_halt(core_halt), .instr(instr));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task stop_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Request held until waitrequest is sampled low at a rising edge; data taken and request dropped there
  task bus(input logic we, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int k;
    @(posedge clk);
    avs_address <= a;
    avs_write <= we;
    avs_read <= !we;
    avs_writedata <= wd;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 20);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (k >= 20) begin
      fail_count++;
      stop_test;
    end
  endtask

  task rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    bus(1'b0, a, 32'h0, d);
    chk(d & m, e);
  endtask

  task wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task nap(input int k);
    repeat (k) @(posedge clk);
  endtask

  // Counts falling edges until the core is let go, bounded
  task wake_wait;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (resume_next !== 1'b1 && irq_entry !== 1'b1 && n < 3000);
  endtask

  task halt_now;
    i_pdww_core_model.exec(4'h8);
    @(negedge clk);
  endtask

  task pin_wake;
    @(posedge clk);
    wake_port[0] <= 1'b0;
    wake_wait;
    nap(1);
    wake_port <= 8'hFF;
    nap(8);
  endtask

  initial begin
    repeat (30000) @(posedge clk);
    fail_count++;
    stop_test;
  end

  initial begin
    reset_n = 1'b0;
    external_reset_pin_n = 1'b1;
    wake_port = 8'hFF;
    wdog_osc = 1'b0;
    stack_full = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    irq_req = 4'h0;
    irq_en = 4'h0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    {fail_count, check_count} = 0;
    nap(20);
    reset_n <= 1'b1;
    rd(`PDWW_CONFIG_OFS, 32'hFFFFFFFF, 32'h00000001);
    rd(`PDWW_STATUS_OFS, 32'hFFFFFFFF, 32'h0);
    rd(4'hC, 32'hFFFFFFFF, 32'h0);
    wr(`PDWW_CONFIG_OFS, 32'h00000101);
    wr(`PDWW_STATUS_OFS, 32'hFFFFFFFF);
    rd(`PDWW_STATUS_OFS, 32'hFFFFFFFF, 32'h0);
    rd(`PDWW_CONFIG_OFS, 32'hFFFFFFFF, 32'h00000101);
    // Halt on the oscillator source: counting goes on
    halt_now;
    chk(core_halt, 1'b1);
    chk(sys_osc_run, 1'b0);
    rd(`PDWW_STATUS_OFS, 32'h0000000F, 32'h5);
    rd(`PDWW_COUNT_OFS, 32'h0000FFFF, 32'h0);
    repeat (3) begin
      nap(6);
      wdog_osc <= 1'b1;
      nap(6);
      wdog_osc <= 1'b0;
    end
    rd(`PDWW_COUNT_OFS, 32'h0000FFFF, 32'h3);
    wake_port[1] <= 1'b0;
    nap(20);
    @(negedge clk);
    chk(core_halt, 1'b1);
    pin_wake;
    chk(n >= 1026 && n <= 1032, 1'b1);
    rd(`PDWW_STATUS_OFS, 32'h0000000F, 32'h1);
    i_pdww_core_model.exec(4'h4);
    rd(`PDWW_STATUS_OFS, 32'h00000003, 32'h0);
    // Paired clears on the divided system clock, frozen while halted
    wr(`PDWW_CONFIG_OFS, 32'h00000107);
    halt_now;
    rd(`PDWW_COUNT_OFS, 32'h0000FFFF, 32'h0);
    nap(40);
    rd(`PDWW_COUNT_OFS, 32'h0000FFFF, 32'h0);
    pin_wake;
    i_pdww_core_model.exec(4'h2);
    i_pdww_core_model.exec(4'h2);
    rd(`PDWW_STATUS_OFS, 32'h00000001, 32'h1);
    i_pdww_core_model.exec(4'h1);
    rd(`PDWW_STATUS_OFS, 32'h00000001, 32'h0);
    // Watchdog disabled: clear is a no-operation
    wr(`PDWW_CONFIG_OFS, 32'h00000100);
    halt_now;
    pin_wake;
    i_pdww_core_model.exec(4'h4);
    rd(`PDWW_STATUS_OFS, 32'h00000001, 32'h1);
    // Interrupt wakes: serviceable, then with the stack full
    wr(`PDWW_CONFIG_OFS, 32'h00000001);
    irq_en <= 4'h1;
    halt_now;
    @(posedge clk);
    irq_req <= 4'h1;
    wake_wait;
    chk(irq_entry, 1'b1);
    chk(n >= 1025 && n <= 1030, 1'b1);
    irq_req <= 4'h0;
    stack_full <= 1'b1;
    halt_now;
    @(posedge clk);
    irq_req <= 4'h1;
    wake_wait;
    chk(resume_next, 1'b1);
    nap(1);
    {irq_req, stack_full} <= 5'h04;
    // Request already set before halting cannot wake
    halt_now;
    nap(30);
    @(negedge clk);
    chk(core_halt, 1'b1);
    @(posedge clk);
    external_reset_pin_n <= 1'b0;
    nap(10);
    @(negedge clk);
    chk(system_reset, 1'b1);
    chk(core_halt, 1'b0);
    rd(`PDWW_COUNT_OFS, 32'h0000FFFF, 32'h0);
    external_reset_pin_n <= 1'b1;
    irq_req <= 4'h0;
    nap(10);
    stop_test;
  end
endmodule
